/* ppi_pkg.sv */
// Package with register map, field layout, reset values and mode codes of the port block.
package ppi_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_A_DATA = 4'h0;
  localparam logic [3:0] OFS_B_DATA = 4'h1;
  localparam logic [3:0] OFS_A_DIR = 4'h2;
  localparam logic [3:0] OFS_B_DIR = 4'h3;
  localparam logic [3:0] OFS_E_DATA = 4'h4;
  localparam logic [3:0] OFS_E_DIR = 4'h5;
  localparam logic [3:0] OFS_J_DRIVE = 4'h6;
  localparam logic [3:0] OFS_J_PULL = 4'h7;
  localparam logic [3:0] OFS_J_DATA = 4'h8;
  localparam logic [3:0] OFS_J_DIR = 4'h9;
  localparam logic [3:0] OFS_CTRL = 4'hA;
  localparam logic [3:0] OFS_STATUS = 4'hB;
  localparam logic [7:0] J_IMPL_MASK = 8'hF7;
  localparam logic [7:0] J_PULL_RESET = 8'hF7;
  localparam logic [7:0] ZERO8 = 8'h00;
  // Control register fields, control port pin numbers and the divider reset value.
  localparam int unsigned CTL_CORE_CLK_EN = 0;
  localparam int unsigned CTL_BUS_CLK_EN = 1;
  localparam int unsigned CTL_BUS_CLK_DIV = 2;
  localparam int unsigned CTL_IRQ_EN = 3;
  localparam int unsigned CTL_IRQ_EDGE = 4;
  localparam int unsigned CTL_E_ALT = 5;
  localparam int unsigned CTL_J_PULL_DOWN = 6;
  localparam int unsigned E_CORE_CLK_PIN = 7;
  localparam int unsigned E_BUS_CLK_PIN = 4;
  localparam int unsigned E_IRQ_PIN = 1;
  localparam int unsigned E_NMI_PIN = 0;
  localparam logic [7:0] DIV_RESET = 8'h01;
  typedef enum logic [2:0] {
    PPI_MODE_SINGLE = 3'b000,
    PPI_MODE_NORMAL_EXP = 3'b001,
    PPI_MODE_EMUL_SINGLE = 3'b010,
    PPI_MODE_EMUL_EXP = 3'b011,
    PPI_MODE_SPECIAL_TEST = 3'b100,
    PPI_MODE_SPECIAL_SINGLE = 3'b101
  } ppi_mode_t;
endpackage

/* ppi_gpio_bit.sv */
// One general purpose pin: drive, enable and read-back selection.
`timescale 1ns/100ps
module ppi_gpio_bit (
  input wire logic data_i,
  input wire logic dir_i,
  input wire logic pin_in_i,
  input wire logic alt_en_i,
  input wire logic alt_val_i,
  output logic pin_out_o,
  output logic pin_oe_n_o,
  output logic read_o
);
  always_comb begin
    pin_out_o = alt_en_i ? alt_val_i : data_i;
    pin_oe_n_o = !(alt_en_i || dir_i);
    read_o = dir_i ? data_i : pin_in_i;
  end
endmodule

/* ppi_clk_div.sv */
// Bus-rate clock output divider; a divide value of zero or one toggles the output on every rising reference clock edge.
`timescale 1ns/100ps
module ppi_clk_div (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] div_i,
  output logic tick_o
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic phase;
  logic next_phase;
  always_comb begin
    next_cnt = cnt + 8'h01;
    next_phase = phase;
    if (cnt + 8'h01 >= div_i) begin
      next_cnt = 8'h00;
      next_phase = !phase;
    end
  end
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt <= 8'h00;
      phase <= 1'b0;
    end else begin
      cnt <= next_cnt;
      phase <= next_phase;
    end
  end
  assign tick_o = phase;
endmodule

/* ppi_port_top.sv */
// Port pin integration: address ports, drive-configurable port and control port.
`timescale 1ns/100ps
module ppi_port_top #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [2:0] mode_ab_i,
  input wire logic background_debug_pin_i,
  input wire logic core_clk_i,
  input wire logic [15:0] ext_addr_i,
  input wire logic upper_data_select_i,
  input wire logic [7:0] ext_bus_rdata_i,
  output logic ext_dir_wr_o,
  output logic [7:0] ext_dir_wdata_o,
  input wire logic [5:0] bus_ctrl_i,
  input wire logic cpu_i_mask_i,
  input wire logic cpu_x_mask_i,
  output logic irq_req_o,
  output logic nmi_req_o,
  output logic mode_select_c_o,
  input wire logic [WIDTH-1:0] address_high_pins_i,
  output logic [WIDTH-1:0] address_high_pins_o,
  output logic [WIDTH-1:0] address_high_pins_oe_n_o,
  input wire logic [WIDTH-1:0] address_low_pins_i,
  output logic [WIDTH-1:0] address_low_pins_o,
  output logic [WIDTH-1:0] address_low_pins_oe_n_o,
  input wire logic [WIDTH-1:0] control_port_pins_i,
  output logic [WIDTH-1:0] control_port_pins_o,
  output logic [WIDTH-1:0] control_port_pins_oe_n_o,
  input wire logic [WIDTH-1:0] extra_port_pins_i,
  output logic [WIDTH-1:0] extra_port_pins_o,
  output logic [WIDTH-1:0] extra_port_pins_oe_n_o,
  output logic [WIDTH-1:0] reduced_drive_select_o,
  output logic [WIDTH-1:0] pull_device_enable_o,
  output logic [WIDTH-1:0] pull_up_select_o
);
  logic [7:0] a_data, b_data, a_dir, b_dir, e_data, e_dir, j_data, j_dir, j_drv, j_pull;
  logic [7:0] ctrl, div;
  logic [7:0] next_a_data, next_b_data, next_a_dir, next_b_dir, next_e_data, next_e_dir;
  logic [7:0] next_j_data, next_j_dir, next_j_drv, next_j_pull, next_ctrl, next_div;
  logic [2:0] mode, next_mode;
  logic mode_select_c, next_mode_select_c;
  logic in_reset, next_in_reset;
  logic [7:0] rdata, next_rdata;
  logic dir_fwd, next_dir_fwd;
  logic [7:0] dir_fwd_data, next_dir_fwd_data;
  logic irq_prev, next_irq_prev;
  logic expanded, emulation, test_mode;
  logic bus_tick;
  logic [7:0] a_rd, b_rd, e_rd, j_rd;
  logic [7:0] e_alt_en, e_alt_val, b_alt_val;
  localparam logic [7:0] OFS_DIV = 8'h0C;

  // Mode strap is captured on the first clock edge after reset falls by a clocked process, not by the reset itself.
  always_comb begin
    next_in_reset = 1'b0;
    next_mode = mode;
    next_mode_select_c = mode_select_c;
    if (in_reset) begin
      next_mode = {background_debug_pin_i, mode_ab_i[1:0]};
      next_mode_select_c = background_debug_pin_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      in_reset <= 1'b1;
      mode <= 3'h0;
      mode_select_c <= 1'b0;
    end else begin
      in_reset <= next_in_reset;
      mode <= next_mode;
      mode_select_c <= next_mode_select_c;
    end
  end

  always_comb begin
    expanded = (mode == ppi_pkg::PPI_MODE_NORMAL_EXP) || (mode == ppi_pkg::PPI_MODE_EMUL_EXP)
        || (mode == ppi_pkg::PPI_MODE_SPECIAL_TEST);
    emulation = (mode == ppi_pkg::PPI_MODE_EMUL_SINGLE) || (mode == ppi_pkg::PPI_MODE_EMUL_EXP);
    test_mode = (mode == ppi_pkg::PPI_MODE_SPECIAL_TEST);
  end

  // Register writes.
  always_comb begin
    next_a_data = a_data;
    next_b_data = b_data;
    next_a_dir = a_dir;
    next_b_dir = b_dir;
    next_e_data = e_data;
    next_e_dir = e_dir;
    next_j_data = j_data;
    next_j_dir = j_dir;
    next_j_drv = j_drv;
    next_j_pull = j_pull;
    next_ctrl = ctrl;
    next_div = div;
    next_dir_fwd = 1'b0;
    next_dir_fwd_data = dir_fwd_data;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        ppi_pkg::OFS_A_DATA: next_a_data = reg_wdata_i;
        ppi_pkg::OFS_B_DATA: next_b_data = reg_wdata_i;
        ppi_pkg::OFS_A_DIR: begin
          next_a_dir = reg_wdata_i;
          if (emulation) begin
            next_dir_fwd = 1'b1;
            next_dir_fwd_data = reg_wdata_i;
          end
        end
        ppi_pkg::OFS_B_DIR: next_b_dir = reg_wdata_i;
        ppi_pkg::OFS_E_DATA: next_e_data = reg_wdata_i;
        ppi_pkg::OFS_E_DIR: next_e_dir = reg_wdata_i;
        ppi_pkg::OFS_J_DRIVE: next_j_drv = reg_wdata_i & ppi_pkg::J_IMPL_MASK;
        ppi_pkg::OFS_J_PULL: next_j_pull = reg_wdata_i & ppi_pkg::J_IMPL_MASK;
        ppi_pkg::OFS_J_DATA: next_j_data = reg_wdata_i;
        ppi_pkg::OFS_J_DIR: next_j_dir = reg_wdata_i;
        ppi_pkg::OFS_CTRL: next_ctrl = reg_wdata_i;
        OFS_DIV[3:0]: next_div = reg_wdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      a_data <= ppi_pkg::ZERO8;
      b_data <= ppi_pkg::ZERO8;
      a_dir <= ppi_pkg::ZERO8;
      b_dir <= ppi_pkg::ZERO8;
      e_data <= ppi_pkg::ZERO8;
      e_dir <= ppi_pkg::ZERO8;
      j_data <= ppi_pkg::ZERO8;
      j_dir <= ppi_pkg::ZERO8;
      j_drv <= ppi_pkg::ZERO8;
      j_pull <= ppi_pkg::J_PULL_RESET;
      ctrl <= ppi_pkg::ZERO8;
      div <= ppi_pkg::DIV_RESET;
      dir_fwd <= 1'b0;
      dir_fwd_data <= ppi_pkg::ZERO8;
    end else begin
      a_data <= next_a_data;
      b_data <= next_b_data;
      a_dir <= next_a_dir;
      b_dir <= next_b_dir;
      e_data <= next_e_data;
      e_dir <= next_e_dir;
      j_data <= next_j_data;
      j_dir <= next_j_dir;
      j_drv <= next_j_drv;
      j_pull <= next_j_pull;
      ctrl <= next_ctrl;
      div <= next_div;
      dir_fwd <= next_dir_fwd;
      dir_fwd_data <= next_dir_fwd_data;
    end
  end

  ppi_clk_div u_div (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .div_i(div),
    .tick_o(bus_tick)
  );

  // Alternate functions of the control port and of low address bit 0.
  always_comb begin
    b_alt_val = ext_addr_i[7:0];
    if (!emulation && !test_mode) begin
      b_alt_val[0] = upper_data_select_i;
    end
    e_alt_en = ppi_pkg::ZERO8;
    e_alt_val = ppi_pkg::ZERO8;
    e_alt_en[ppi_pkg::E_CORE_CLK_PIN] = ctrl[ppi_pkg::CTL_CORE_CLK_EN] || emulation;
    e_alt_val[ppi_pkg::E_CORE_CLK_PIN] = core_clk_i;
    e_alt_en[ppi_pkg::E_BUS_CLK_PIN] = ctrl[ppi_pkg::CTL_BUS_CLK_EN] || emulation;
    e_alt_val[ppi_pkg::E_BUS_CLK_PIN] = ctrl[ppi_pkg::CTL_BUS_CLK_DIV] ? bus_tick
        : ref_clk_i;
    if (ctrl[ppi_pkg::CTL_E_ALT] || expanded) begin
      e_alt_en[6:5] = 2'h3;
      e_alt_val[6:5] = bus_ctrl_i[4:3];
      e_alt_en[3:2] = 2'h3;
      e_alt_val[3:2] = bus_ctrl_i[1:0];
    end
  end

  // Per-pin multiplexing for the four ports.
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      logic e_gpio_dir;
      assign e_gpio_dir = (g > ppi_pkg::E_IRQ_PIN) ? e_dir[g] : 1'b0;
      ppi_gpio_bit u_a (
        .data_i(a_data[g]),
        .dir_i(a_dir[g]),
        .pin_in_i(address_high_pins_i[g]),
        .alt_en_i(expanded),
        .alt_val_i(ext_addr_i[8 + g]),
        .pin_out_o(address_high_pins_o[g]),
        .pin_oe_n_o(address_high_pins_oe_n_o[g]),
        .read_o(a_rd[g])
      );
      ppi_gpio_bit u_b (
        .data_i(b_data[g]),
        .dir_i(b_dir[g]),
        .pin_in_i(address_low_pins_i[g]),
        .alt_en_i(expanded),
        .alt_val_i(b_alt_val[g]),
        .pin_out_o(address_low_pins_o[g]),
        .pin_oe_n_o(address_low_pins_oe_n_o[g]),
        .read_o(b_rd[g])
      );
      // Pins 1 and 0 of the control port are input only.
      ppi_gpio_bit u_e (
        .data_i(e_data[g]),
        .dir_i(e_gpio_dir),
        .pin_in_i(control_port_pins_i[g]),
        .alt_en_i(e_alt_en[g]),
        .alt_val_i(e_alt_val[g]),
        .pin_out_o(control_port_pins_o[g]),
        .pin_oe_n_o(control_port_pins_oe_n_o[g]),
        .read_o(e_rd[g])
      );
      ppi_gpio_bit u_j (
        .data_i(j_data[g]),
        .dir_i(j_dir[g]),
        .pin_in_i(extra_port_pins_i[g]),
        .alt_en_i(1'b0),
        .alt_val_i(1'b0),
        .pin_out_o(extra_port_pins_o[g]),
        .pin_oe_n_o(extra_port_pins_oe_n_o[g]),
        .read_o(j_rd[g])
      );
      // Push-pull outputs ignore the pull bit; inputs ignore reduced drive.
      assign reduced_drive_select_o[g] = j_drv[g] && j_dir[g];
      assign pull_device_enable_o[g] = j_pull[g] && !j_dir[g];
      assign pull_up_select_o[g] = !ctrl[ppi_pkg::CTL_J_PULL_DOWN];
    end
  endgenerate

  // Interrupt qualification; the edge detector sees pin level of the previous cycle.
  always_comb begin
    next_irq_prev = control_port_pins_i[ppi_pkg::E_IRQ_PIN];
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_prev <= 1'b1;
    end else begin
      irq_prev <= next_irq_prev;
    end
  end

  always_comb begin
    irq_req_o = 1'b0;
    if (ctrl[ppi_pkg::CTL_IRQ_EN] && !cpu_i_mask_i) begin
      irq_req_o = ctrl[ppi_pkg::CTL_IRQ_EDGE]
          ? (irq_prev && !control_port_pins_i[ppi_pkg::E_IRQ_PIN])
          : !control_port_pins_i[ppi_pkg::E_IRQ_PIN];
    end
    nmi_req_o = !cpu_x_mask_i && !control_port_pins_i[ppi_pkg::E_NMI_PIN];
  end

  // Read path, data valid in the cycle after the strobe.
  always_comb begin
    next_rdata = ppi_pkg::ZERO8;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ppi_pkg::OFS_A_DATA: next_rdata = a_rd;
        ppi_pkg::OFS_B_DATA: next_rdata = b_rd;
        ppi_pkg::OFS_A_DIR: next_rdata = emulation ? ext_bus_rdata_i : a_dir;
        ppi_pkg::OFS_B_DIR: next_rdata = b_dir;
        ppi_pkg::OFS_E_DATA: next_rdata = e_rd;
        ppi_pkg::OFS_E_DIR: next_rdata = e_dir;
        ppi_pkg::OFS_J_DRIVE: next_rdata = j_drv;
        ppi_pkg::OFS_J_PULL: next_rdata = j_pull;
        ppi_pkg::OFS_J_DATA: next_rdata = j_rd;
        ppi_pkg::OFS_J_DIR: next_rdata = j_dir;
        ppi_pkg::OFS_CTRL: next_rdata = ctrl;
        ppi_pkg::OFS_STATUS: next_rdata = {4'h0, mode_select_c, mode};
        OFS_DIV[3:0]: next_rdata = div;
        default: next_rdata = ppi_pkg::ZERO8;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata <= ppi_pkg::ZERO8;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign reg_rdata_o = rdata;
  assign ext_dir_wr_o = dir_fwd;
  assign ext_dir_wdata_o = dir_fwd_data;
  assign mode_select_c_o = mode_select_c;

  default clocking cb_main @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  property p_fwd; reg_wr_i && reg_addr_i == ppi_pkg::OFS_A_DIR && emulation
      |=> ext_dir_wr_o && ext_dir_wdata_o == $past(reg_wdata_i); endproperty
  a_fwd: assert property (p_fwd) else $error("direction write not forwarded");
  property p_nofwd; !emulation |=> !ext_dir_wr_o; endproperty
  a_nofwd: assert property (p_nofwd) else $error("forward outside emulation");
  property p_rd_dir; reg_rd_i && reg_addr_i == ppi_pkg::OFS_A_DIR && emulation
      |=> reg_rdata_o == $past(ext_bus_rdata_i); endproperty
  a_rd_dir: assert property (p_rd_dir) else $error("emulated direction read wrong");
  property p_rd_a; reg_rd_i && reg_addr_i == ppi_pkg::OFS_A_DATA && !expanded
      |=> reg_rdata_o == (($past(a_dir) & $past(a_data))
      | (~$past(a_dir) & $past(address_high_pins_i))); endproperty
  a_rd_a: assert property (p_rd_a) else $error("port read wrong");
  property p_addr; expanded |-> address_high_pins_o == ext_addr_i[15:8]
      && address_high_pins_oe_n_o == ppi_pkg::ZERO8; endproperty
  a_addr: assert property (p_addr) else $error("address high not driven");
  property p_j_bit3; reg_wr_i && reg_addr_i == ppi_pkg::OFS_J_PULL
      |=> (j_pull & ~ppi_pkg::J_IMPL_MASK) == ppi_pkg::ZERO8; endproperty
  a_j_bit3: assert property (p_j_bit3) else $error("bit 3 implemented");
  property p_nmi; cpu_x_mask_i |-> !nmi_req_o; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi while masked");
  property p_irq; irq_req_o |-> ctrl[ppi_pkg::CTL_IRQ_EN] && !cpu_i_mask_i; endproperty
  a_irq: assert property (p_irq) else $error("irq while disabled");
  property p_clk; emulation |-> !control_port_pins_oe_n_o[ppi_pkg::E_CORE_CLK_PIN]
      && !control_port_pins_oe_n_o[ppi_pkg::E_BUS_CLK_PIN]; endproperty
  a_clk: assert property (p_clk) else $error("clock output not forced");
  c_fwd: cover property (@(posedge ref_clk_i) ext_dir_wr_o);
  c_irq: cover property (@(posedge ref_clk_i) irq_req_o);
  c_exp: cover property (@(posedge ref_clk_i) expanded && reg_rd_i);
endmodule

/* ppi_board_model.sv */
// Board side of one 8-pin port: resolves the pad level from the chip and the board drivers.
`timescale 1ns/100ps
module ppi_board_model (
  input wire logic [7:0] pin_out_i,
  input wire logic [7:0] pin_oe_n_i,
  input wire logic [7:0] board_val_i,
  input wire logic [7:0] board_en_i,
  output logic [7:0] level_o
);
  // An undriven pad is held high by the board pull-up, so a floating pin never reads as a
  // stale value; the chip wins a pin it drives, which is what the bench expects to see.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pin_oe_n_i[i]) begin
        level_o[i] = pin_out_i[i];
      end else if (board_en_i[i]) begin
        level_o[i] = board_val_i[i];
      end else begin
        level_o[i] = 1'b1;
      end
    end
  end
endmodule

/* ppi_port_top_tb_top.sv */
// Self-checking testbench of the port pin integration block.
`timescale 1ns/100ps
module ppi_port_top_tb_top;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic [2:0] mode_ab_i = 3'h0;
  logic background_debug_pin_i = 1'b0;
  logic core_clk_i = 1'b0;
  logic [15:0] ext_addr_i = 16'h0000;
  logic upper_data_select_i = 1'b0;
  logic [7:0] ext_bus_rdata_i = 8'h00;
  logic ext_dir_wr_o;
  logic [7:0] ext_dir_wdata_o;
  logic [5:0] bus_ctrl_i = 6'h00;
  logic cpu_i_mask_i = 1'b1;
  logic cpu_x_mask_i = 1'b1;
  logic irq_req_o, nmi_req_o, mode_select_c_o;
  logic [7:0] a_o, a_oe_n, b_o, b_oe_n, e_o, e_oe_n, k_o, k_oe_n;
  logic [7:0] reduced_drive_select_o, pull_device_enable_o, pull_up_select_o;
  logic [7:0] bval [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] ben [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] lvl [4];
  int fails = 0;
  int tests_run = 0;

  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  ppi_board_model pa (.pin_out_i(a_o), .pin_oe_n_i(a_oe_n), .board_val_i(bval[0]),
    .board_en_i(ben[0]), .level_o(lvl[0]));
  ppi_board_model pb (.pin_out_i(b_o), .pin_oe_n_i(b_oe_n), .board_val_i(bval[1]),
    .board_en_i(ben[1]), .level_o(lvl[1]));
  ppi_board_model pe (.pin_out_i(e_o), .pin_oe_n_i(e_oe_n), .board_val_i(bval[2]),
    .board_en_i(ben[2]), .level_o(lvl[2]));
  ppi_board_model pk (.pin_out_i(k_o), .pin_oe_n_i(k_oe_n), .board_val_i(bval[3]),
    .board_en_i(ben[3]), .level_o(lvl[3]));

  ppi_port_top dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .mode_ab_i(mode_ab_i),
    .background_debug_pin_i(background_debug_pin_i), .core_clk_i(core_clk_i),
    .ext_addr_i(ext_addr_i), .upper_data_select_i(upper_data_select_i),
    .ext_bus_rdata_i(ext_bus_rdata_i), .ext_dir_wr_o(ext_dir_wr_o),
    .ext_dir_wdata_o(ext_dir_wdata_o), .bus_ctrl_i(bus_ctrl_i), .cpu_i_mask_i(cpu_i_mask_i),
    .cpu_x_mask_i(cpu_x_mask_i), .irq_req_o(irq_req_o), .nmi_req_o(nmi_req_o),
    .mode_select_c_o(mode_select_c_o), .address_high_pins_i(lvl[0]),
    .address_high_pins_o(a_o), .address_high_pins_oe_n_o(a_oe_n),
    .address_low_pins_i(lvl[1]), .address_low_pins_o(b_o), .address_low_pins_oe_n_o(b_oe_n),
    .control_port_pins_i(lvl[2]), .control_port_pins_o(e_o),
    .control_port_pins_oe_n_o(e_oe_n), .extra_port_pins_i(lvl[3]), .extra_port_pins_o(k_o),
    .extra_port_pins_oe_n_o(k_oe_n), .reduced_drive_select_o(reduced_drive_select_o),
    .pull_device_enable_o(pull_device_enable_o), .pull_up_select_o(pull_up_select_o));

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  // The strap is applied on the same edge that raises reset and held after it falls, so it is stable when sampled.
  task automatic do_reset(input logic [2:0] m);
    @(posedge ref_clk_i);
    background_debug_pin_i <= m[2];
    mode_ab_i <= {1'b0, m[1:0]};
    reset_i <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
  endtask

  function automatic logic [15:0] pv(input int k);
    case (k)
      0: pv = {a_oe_n, a_o};
      1: pv = {b_oe_n, b_o};
      2: pv = {e_oe_n, e_o};
      default: pv = {k_oe_n, k_o};
    endcase
  endfunction

  task automatic t_reset_values;
    logic [7:0] d;
    rd(ppi_pkg::OFS_J_PULL, d);
    check("pull_reg", d, ppi_pkg::J_PULL_RESET);
    check("pull_en", pull_device_enable_o, 8'hF7);
    check("pull_up", pull_up_select_o & 8'hF7, 8'hF7);
    check("e_oe_n", e_oe_n, 8'hFF);
    check("irq", irq_req_o, 1'b0);
    check("nmi", nmi_req_o, 1'b0);
    rd(4'hF, d);
    check("unmapped", d, 8'h00);
  endtask

  task automatic t_gpio;
    logic [3:0] dofs [4] = '{ppi_pkg::OFS_A_DATA, ppi_pkg::OFS_B_DATA, ppi_pkg::OFS_E_DATA,
      ppi_pkg::OFS_J_DATA};
    logic [3:0] rofs [4] = '{ppi_pkg::OFS_A_DIR, ppi_pkg::OFS_B_DIR, ppi_pkg::OFS_E_DIR,
      ppi_pkg::OFS_J_DIR};
    logic [7:0] d;
    for (int k = 0; k < 4; k++) begin
      bval[k] <= 8'h3C;
      ben[k] <= 8'hFF;
      wr(rofs[k], 8'hF0);
      check("ext_wr", ext_dir_wr_o, 1'b0);
      wr(dofs[k], 8'hA5);
      check("gpio_out", pv(k) & 16'hFFF0, 16'h0FA0);
      rd(dofs[k], d);
      check("gpio_read", d, 8'hAC);
      rd(rofs[k], d);
      check("dir_read", d, 8'hF0);
      wr(rofs[k], 8'h00);
      ben[k] <= 8'h00;
    end
  endtask

  task automatic t_j_port;
    logic [7:0] d;
    wr(ppi_pkg::OFS_J_DRIVE, 8'hFF);
    wr(ppi_pkg::OFS_J_PULL, 8'hFF);
    wr(ppi_pkg::OFS_J_DIR, 8'h0F);
    rd(ppi_pkg::OFS_J_DRIVE, d);
    check("drive_reg", d, 8'hF7);
    rd(ppi_pkg::OFS_J_PULL, d);
    check("pull_reg", d, 8'hF7);
    check("reduced", reduced_drive_select_o, 8'h07);
    check("pull_en", pull_device_enable_o, 8'hF0);
    wr(ppi_pkg::OFS_CTRL, 8'h40);
    check("pull_down", pull_up_select_o, 8'h00);
  endtask

  task automatic t_expanded;
    logic [2:0] modes [3] = '{3'd1, 3'd3, 3'd4};
    logic [7:0] d;
    ext_addr_i <= 16'hB6E9;
    for (int i = 0; i < 3; i++) begin
      do_reset(modes[i]);
      #1;
      check("mode_select_c", mode_select_c_o, modes[i][2]);
      check("addr_hi", {a_oe_n, a_o}, 16'h00B6);
      check("addr_lo", b_o, (modes[i] == 3'd1) ? 8'hE8 : 8'hE9);
      check("addr_lo_oe", b_oe_n, 8'h00);
      rd(ppi_pkg::OFS_STATUS, d);
      check("status", d, {4'h0, modes[i][2], modes[i]});
    end
  endtask

  task automatic t_emulation;
    logic [7:0] d;
    do_reset(3'd2);
    wr(ppi_pkg::OFS_A_DIR, 8'h5A);
    check("ext_wr", {ext_dir_wr_o, ext_dir_wdata_o}, 16'h015A);
    @(posedge ref_clk_i);
    #1 check("ext_wr_end", ext_dir_wr_o, 1'b0);
    ext_bus_rdata_i <= 8'h96;
    rd(ppi_pkg::OFS_A_DIR, d);
    check("dir_ext", d, 8'h96);
    check("clk_oe", {e_oe_n[7], e_oe_n[4]}, 2'b00);
    @(posedge ref_clk_i);
    core_clk_i <= 1'b1;
    #1 check("core_clk", e_o[7], 1'b1);
    @(posedge ref_clk_i);
    core_clk_i <= 1'b0;
    #1 check("core_clk", e_o[7], 1'b0);
  endtask

  task automatic t_control;
    logic [1:0] seen;
    int flips;
    logic last;
    do_reset(3'd0);
    #1 check("clk_oe_off", {e_oe_n[7], e_oe_n[4]}, 2'b11);
    wr(ppi_pkg::OFS_CTRL, 8'h23);
    check("clk_oe_on", {e_oe_n[7], e_oe_n[4]}, 2'b00);
    seen = 2'b00;
    repeat (4) begin
      @(posedge ref_clk_i);
      #1 seen[e_o[4]] = 1'b1;
      @(negedge ref_clk_i);
      #1 seen[e_o[4]] = 1'b1;
    end
    check("bus_clk_toggles", seen, 2'b11);
    // A divide value of three toggles the pin every third edge, so twelve edges give four.
    wr(4'hC, 8'h03);
    wr(ppi_pkg::OFS_CTRL, 8'h27);
    flips = 0;
    last = e_o[4];
    repeat (12) begin
      @(posedge ref_clk_i);
      #1 flips += (e_o[4] != last) ? 1 : 0;
      last = e_o[4];
    end
    check("bus_clk_div", flips[15:0], 16'h0004);
    for (int v = 0; v < 2; v++) begin
      @(posedge ref_clk_i);
      bus_ctrl_i <= v ? 6'h00 : 6'h1B;
      #1 check("bus_ctl", {e_o[6:5], e_o[3:2]}, v ? 4'h0 : 4'hF);
    end
  endtask

  task automatic t_interrupts;
    int pulses;
    bval[2] <= 8'hFC;
    ben[2] <= 8'h03;
    cpu_i_mask_i <= 1'b0;
    @(posedge ref_clk_i);
    #1 check("irq_off", irq_req_o, 1'b0);
    wr(ppi_pkg::OFS_CTRL, 8'h08);
    check("irq_level", irq_req_o, 1'b1);
    @(posedge ref_clk_i);
    cpu_i_mask_i <= 1'b1;
    #1 check("irq_masked", irq_req_o, 1'b0);
    bval[2] <= 8'hFF;
    cpu_i_mask_i <= 1'b0;
    wr(ppi_pkg::OFS_CTRL, 8'h18);
    @(posedge ref_clk_i);
    bval[2] <= 8'hFD;
    pulses = 0;
    repeat (6) begin
      #1 pulses += irq_req_o ? 1 : 0;
      @(posedge ref_clk_i);
    end
    check("irq_edge", pulses[15:0], 16'h0001);
    bval[2] <= 8'hFE;
    @(posedge ref_clk_i);
    #1 check("nmi_masked", nmi_req_o, 1'b0);
    cpu_x_mask_i <= 1'b0;
    @(posedge ref_clk_i);
    #1 check("nmi_level", nmi_req_o, 1'b1);
    cpu_x_mask_i <= 1'b1;
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk_i);
    fails++;
    complete_run();
  end

  initial begin
    do_reset(3'd0);
    t_reset_values();
    t_gpio();
    t_j_port();
    t_expanded();
    t_emulation();
    t_control();
    t_interrupts();
    complete_run();
  end
endmodule
